// File: design/tcr_pkg.sv
// Package for the test access port with clock and reset restrictions.
// Assumes a single 200 MHz system clock that samples all test pins.
package tcr_pkg;

	localparam int IR_WIDTH  = 3;
	localparam int BSR_WIDTH = 6;
	localparam int PIN_COUNT = 4;

	// Instruction codes; any code not listed selects the bypass bit.
	localparam logic [IR_WIDTH-1:0] INSTR_EXTEST     = 3'h0;
	localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE     = 3'h1;
	localparam logic [IR_WIDTH-1:0] INSTR_HIGHZ      = 3'h2;
	localparam logic [IR_WIDTH-1:0] INSTR_DRIVE_CTL  = 3'h3;
	localparam logic [IR_WIDTH-1:0] INSTR_POWER_DOWN = 3'h4;
	localparam logic [IR_WIDTH-1:0] INSTR_BYPASS     = 3'h7;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 3'h1;
	localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE   = INSTR_BYPASS;

	// Boundary cell positions, bit 0 nearest the serial output.
	localparam int CELL_LOCKED_XFER     = 0;
	localparam int CELL_LOCKED_XFER_END = 1;
	localparam int CELL_XFER_SIZE       = 2;
	localparam int CELL_BUS_REQUEST     = 3;
	localparam int CELL_CTL_IO0         = 4;
	localparam int CELL_CTL_IO1         = 5;
	localparam logic [BSR_WIDTH-1:0] BSR_RESET_VALUE = 6'h00;

	// Bus-clock periods that must still run after first entry to a clock-stoppable instruction.
	localparam logic [1:0] CLK_STOP_BCLK_PERIODS = 2'h2;

	typedef enum logic [3:0] {
		ST_TEST_LOGIC_RESET, ST_RUN_TEST_IDLE,
		ST_SELECT_DR, ST_CAPTURE_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPDATE_DR,
		ST_SELECT_IR, ST_CAPTURE_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPDATE_IR
	} tcr_state_type;

	// Pins sampled from outside the system clock domain.
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic bclk;
		logic pclk;
	} tcr_pins_type;

	// Driven value and enable of each boundary-controlled output pin.
	typedef struct packed {
		logic [PIN_COUNT-1:0] value;
		logic [PIN_COUNT-1:0] oe;
	} tcr_drive_type;

endpackage : tcr_pkg

// File: design/tcr_sync2.sv
// Two-stage synchroniser for the bundle of asynchronous test and clock pins.
// Assumes the inputs change independently of sys_clk.
`timescale 1ns/1ps
module tcr_sync2 (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire tcr_pkg::tcr_pins_type pins_async,
	output      tcr_pkg::tcr_pins_type pins_sync
);
	import tcr_pkg::*;

	tcr_pins_type stage1_reg;
	tcr_pins_type stage2_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end
		else
		begin
			stage1_reg <= pins_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign pins_sync = stage2_reg;

endmodule : tcr_sync2

// File: design/tcr_tap.sv
// Test access port controller with boundary cells and clock-stop sequencing.
// Assumes tck, tms, tdi, trst_n and the bus and processor clocks arrive asynchronously
// and are much slower than sys_clk, so edges can be found by sampling.
`timescale 1ns/1ps
// What this block does
// - Test logic is static; a stopped test clock never loses state.
// - After first entry, two more bus-clock periods pass the internal reset.
// - Switching among the four clock-stoppable instructions needs no system clocks.
// - Test reset forces test-logic-reset asynchronously, without test clock edges.
// - Test mode select is sampled on each rising test clock edge.
// - Release on a rising edge with select low yields reset or idle only.
// - Select low for two periods after release lands in run-test/idle.
// - After a reset pulse, stay in reset until a rising edge with select low.
// - Control cell io.1 enables the locked-transfer and locked-transfer-end outputs.
// - All output-enable control cells clear while in test-logic-reset.
// - Output-only cells go high impedance under the high-impedance instruction.
module tcr_tap (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   trst_n,
	input  wire tcr_pkg::tcr_pins_type  pins_async,
	input  wire tcr_pkg::tcr_drive_type core_drive,
	output      logic                   tdo,
	output      logic                   tdo_oe,
	output      tcr_pkg::tcr_drive_type pin_drive,
	output      logic                   core_reset,
	output      logic                   clocks_free,
	output      logic                   in_test_logic_reset
);
	import tcr_pkg::*;

	tcr_pins_type               pins_sync;
	logic                       tck_prev_reg;
	logic                       bclk_prev_reg;
	logic                       release_stage_reg;
	logic                       release_hold_reg;
	tcr_state_type              state_reg;
	tcr_state_type              state_next;
	logic [IR_WIDTH-1:0]        ir_shift_reg;
	logic [IR_WIDTH-1:0]        instr_reg;
	logic [BSR_WIDTH-1:0]       bsr_shift_reg;
	logic [BSR_WIDTH-1:0]       bsr_update_reg;
	logic                       bypass_reg;
	logic                       tdo_reg;
	logic                       tdo_oe_reg;
	tcr_drive_type              pin_drive_reg;
	tcr_drive_type              pin_drive_next;
	logic                       was_stoppable_reg;
	logic [1:0]                 bclk_count_reg;
	logic                       core_reset_reg;
	logic                       clocks_free_reg;
	logic                       tap_arst;
	logic                       tck_rise;
	logic                       tck_fall;
	logic                       bclk_rise;
	logic                       sel_extest;
	logic                       sel_highz;
	logic                       sel_drive;
	logic                       sel_power_down;
	logic                       sel_bsr;
	logic                       stoppable;
	logic                       first_entry;
	logic                       last_bclk;
	logic                       scan_drives;
	logic [BSR_WIDTH-1:0]       bsr_capture;

	tcr_sync2 u_sync (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.pins_async (pins_async),
		.pins_sync  (pins_sync)
	);

	// Test reset acts with no clock at all; only its release is retimed.
	assign tap_arst  = rst | ~trst_n;
	assign tck_rise  = pins_sync.tck & ~tck_prev_reg;
	assign tck_fall  = ~pins_sync.tck & tck_prev_reg;
	assign bclk_rise = pins_sync.bclk & ~bclk_prev_reg;

	assign sel_extest     = (instr_reg == INSTR_EXTEST);
	assign sel_highz      = (instr_reg == INSTR_HIGHZ);
	assign sel_drive      = (instr_reg == INSTR_DRIVE_CTL);
	assign sel_power_down = (instr_reg == INSTR_POWER_DOWN);
	assign sel_bsr        = sel_extest | sel_drive | (instr_reg == INSTR_SAMPLE);
	assign stoppable      = sel_extest | sel_highz | sel_drive | sel_power_down;
	assign first_entry    = stoppable & ~was_stoppable_reg;
	assign last_bclk      = bclk_rise & (bclk_count_reg == CLK_STOP_BCLK_PERIODS);
	assign scan_drives    = sel_extest | sel_drive;

	// Capture looks at what the core would put on the pins, cells and enables alike.
	assign bsr_capture = {core_drive.oe[CELL_LOCKED_XFER], core_drive.oe[CELL_XFER_SIZE],
		core_drive.value};

	// The whole controller holds its state between sampled edges, so tck may stop at any level.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_TEST_LOGIC_RESET: state_next = pins_sync.tms ? ST_TEST_LOGIC_RESET : ST_RUN_TEST_IDLE;
			ST_RUN_TEST_IDLE:    state_next = pins_sync.tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
			ST_SELECT_DR:        state_next = pins_sync.tms ? ST_SELECT_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR:       state_next = pins_sync.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR:         state_next = pins_sync.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR:         state_next = pins_sync.tms ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR:         state_next = pins_sync.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR:         state_next = pins_sync.tms ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR:        state_next = pins_sync.tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
			ST_SELECT_IR:        state_next = pins_sync.tms ? ST_TEST_LOGIC_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR:       state_next = pins_sync.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR:         state_next = pins_sync.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR:         state_next = pins_sync.tms ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR:         state_next = pins_sync.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR:         state_next = pins_sync.tms ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR:        state_next = pins_sync.tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
		endcase
	end

	// Pin drive: extest and drive-control take the pins from the update cells; high-impedance and power-down clear all enables; the rest take the core drive.
	always_comb
	begin
		pin_drive_next = core_drive;
		if (scan_drives)
		begin
			pin_drive_next.value = bsr_update_reg[PIN_COUNT-1:0];
			pin_drive_next.oe[CELL_LOCKED_XFER]     = bsr_update_reg[CELL_CTL_IO1];
			pin_drive_next.oe[CELL_LOCKED_XFER_END] = bsr_update_reg[CELL_CTL_IO1];
			pin_drive_next.oe[CELL_XFER_SIZE]       = bsr_update_reg[CELL_CTL_IO0];
			pin_drive_next.oe[CELL_BUS_REQUEST]     = 1'b1;
		end
		else if (sel_highz | sel_power_down)
		begin
			pin_drive_next.oe = '0;
		end
	end

	// Release of test reset is taken two sys_clk edges late; until then the controller sits in reset.
	always_ff @(posedge sys_clk or posedge tap_arst)
	begin
		if (tap_arst)
		begin
			release_stage_reg <= 1'b1;
			release_hold_reg  <= 1'b1;
		end
		else
		begin
			release_stage_reg <= 1'b0;
			release_hold_reg  <= release_stage_reg;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tck_prev_reg  <= 1'b0;
			bclk_prev_reg <= 1'b0;
		end
		else
		begin
			tck_prev_reg  <= pins_sync.tck;
			bclk_prev_reg <= pins_sync.bclk;
		end
	end

	// A release landing on a rising edge with select low ends in reset or idle, never elsewhere.
	always_ff @(posedge sys_clk or posedge tap_arst)
	begin
		if (tap_arst)
			state_reg <= ST_TEST_LOGIC_RESET;
		else if (release_hold_reg)
			state_reg <= ST_TEST_LOGIC_RESET;
		else if (tck_rise)
			state_reg <= state_next;
	end

	always_ff @(posedge sys_clk or posedge tap_arst)
	begin
		if (tap_arst)
		begin
			ir_shift_reg   <= IR_RESET_VALUE;
			instr_reg      <= IR_RESET_VALUE;
			bsr_shift_reg  <= BSR_RESET_VALUE;
			bsr_update_reg <= BSR_RESET_VALUE;
			bypass_reg     <= 1'b0;
		end
		else if (state_reg == ST_TEST_LOGIC_RESET)
		begin
			instr_reg      <= IR_RESET_VALUE;
			bsr_update_reg <= BSR_RESET_VALUE;
		end
		else if (tck_rise)
		begin
			unique case (state_reg)
				ST_CAPTURE_IR: ir_shift_reg <= IR_CAPTURE_VALUE;
				ST_SHIFT_IR:   ir_shift_reg <= {pins_sync.tdi, ir_shift_reg[IR_WIDTH-1:1]};
				ST_CAPTURE_DR:
				begin
					bypass_reg <= 1'b0;
					if (sel_bsr)
						bsr_shift_reg <= bsr_capture;
				end
				ST_SHIFT_DR:
				begin
					bypass_reg <= pins_sync.tdi;
					if (sel_bsr)
						bsr_shift_reg <= {pins_sync.tdi, bsr_shift_reg[BSR_WIDTH-1:1]};
				end
				default: ;
			endcase
		end
		else if (tck_fall)
		begin
			// Switching among clock-stoppable instructions uses only the test clock.
			if (state_reg == ST_UPDATE_IR)
				instr_reg <= ir_shift_reg;
			if (state_reg == ST_UPDATE_DR && sel_bsr)
				bsr_update_reg <= bsr_shift_reg;
		end
	end

	// Serial output changes on the falling test clock edge and is enabled only while shifting.
	always_ff @(posedge sys_clk or posedge tap_arst)
	begin
		if (tap_arst)
		begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_oe_reg <= (state_reg == ST_SHIFT_IR) | (state_reg == ST_SHIFT_DR);
			if (state_reg == ST_SHIFT_IR)
				tdo_reg <= ir_shift_reg[0];
			else if (sel_bsr)
				tdo_reg <= bsr_shift_reg[0];
			else
				tdo_reg <= bypass_reg;
		end
	end

	// The internal reset must cross into the bus-clock domain. The first synchronised bus-clock edge
	// may predate the reset by the sync lag, so one edge beyond the two periods is waited for.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			was_stoppable_reg <= 1'b0;
			bclk_count_reg    <= 2'h0;
			core_reset_reg    <= 1'b0;
			clocks_free_reg   <= 1'b0;
		end
		else if (!stoppable)
		begin
			was_stoppable_reg <= 1'b0;
			bclk_count_reg    <= 2'h0;
			core_reset_reg    <= 1'b0;
			clocks_free_reg   <= 1'b0;
		end
		else if (first_entry)
		begin
			was_stoppable_reg <= 1'b1;
			bclk_count_reg    <= 2'h0;
			core_reset_reg    <= 1'b1;
			clocks_free_reg   <= 1'b0;
		end
		else if (core_reset_reg && bclk_rise)
		begin
			bclk_count_reg  <= bclk_count_reg + 2'h1;
			core_reset_reg  <= ~last_bclk;
			clocks_free_reg <= last_bclk;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pin_drive_reg <= '0;
		else
			pin_drive_reg <= pin_drive_next;
	end

	assign tdo                 = tdo_reg;
	assign tdo_oe              = tdo_oe_reg;
	assign pin_drive           = pin_drive_reg;
	assign core_reset          = core_reset_reg;
	assign clocks_free         = clocks_free_reg;
	assign in_test_logic_reset = (state_reg == ST_TEST_LOGIC_RESET);

endmodule : tcr_tap

// File: testbench/tcr_tap_props.sv
// Assertions on the ports of the test access port controller.
// Assumes pins_async are the raw pins, sampled here by sys_clk.
`timescale 1ns/1ps
module tcr_tap_props (
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic                   trst_n,
	input wire tcr_pkg::tcr_pins_type  pins_async,
	input wire tcr_pkg::tcr_drive_type core_drive,
	input wire logic                   tdo,
	input wire logic                   tdo_oe,
	input wire tcr_pkg::tcr_drive_type pin_drive,
	input wire logic                   core_reset,
	input wire logic                   clocks_free,
	input wire logic                   in_test_logic_reset
);
	import tcr_pkg::*;
	logic [1:0] live_reg;
	logic [1:0] bcnt_reg;
	logic [3:0] idle_reg;
	logic       tck_reg;
	logic       bclk_reg;
	logic       tms_reg;
	wire        bclk_rise = pins_async.bclk & ~bclk_reg;
	// Raw bus-clock edges are counted only once the internal reset is up, so each one truly follows it.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			live_reg <= 2'h0;
			bcnt_reg <= 2'h0;
			idle_reg <= 4'h0;
			tck_reg  <= 1'b0;
			bclk_reg <= 1'b0;
			tms_reg  <= 1'b1;
		end
		else
		begin
			live_reg <= live_reg + {1'b0, live_reg != 2'h3};
			bcnt_reg <= core_reset ? bcnt_reg + {1'b0, bclk_rise && bcnt_reg != 2'h3} : 2'h0;
			idle_reg <= (pins_async.tck != tck_reg) ? 4'h0 : idle_reg + {3'h0, idle_reg != 4'hF};
			tck_reg  <= pins_async.tck;
			bclk_reg <= pins_async.bclk;
			tms_reg  <= (pins_async.tck & ~tck_reg) ? pins_async.tms : tms_reg;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	trst_reset_a: assert property (!trst_n |-> in_test_logic_reset)
		else $error("test reset did not force the reset state");
	trst_clear_a: assert property (!trst_n [*2] |-> !clocks_free && !core_reset && !tdo_oe)
		else $error("outputs not cleared under test reset");
	// The instruction clears one edge after the state enters reset and the pins follow one edge later.
	tlr_drive_a: assert property (
		(live_reg == 2'h3 && in_test_logic_reset) [*3] |-> pin_drive.oe == $past(core_drive.oe))
		else $error("scan enables active in reset state");
	gate_count_a: assert property ($rose(clocks_free) |-> bcnt_reg >= 2'h2)
		else $error("clocks freed before two bus-clock periods");
	gate_order_a: assert property ($rose(clocks_free) |-> $past(core_reset))
		else $error("clocks freed without internal reset");
	stop_hold_a: assert property ($fell(clocks_free) |-> idle_reg < 4'hC || in_test_logic_reset || !trst_n)
		else $error("clock freedom lost without test clock activity");
	static_state_a: assert property (
		live_reg == 2'h3 && trst_n && idle_reg == 4'hF |-> $stable(in_test_logic_reset) && $stable(tdo) && $stable(tdo_oe))
		else $error("state changed while test clock stood still");
	tms_exit_a: assert property ($fell(in_test_logic_reset) |-> !tms_reg)
		else $error("reset state left without low select");
	shift_oe_a: assert property ($rose(tdo_oe) |-> !in_test_logic_reset && idle_reg < 4'h8)
		else $error("serial output enabled off a falling edge");
	cover property ($rose(core_reset));
	cover property ($rose(clocks_free));
	cover property ($fell(in_test_logic_reset));
	cover property ($rose(tdo_oe));
endmodule : tcr_tap_props

// File: testbench/tcr_tester.sv
// Board tester model: drives the test pins, test reset and both system clocks.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module tcr_tester (
	output logic                  trst_n,
	output tcr_pkg::tcr_pins_type pins
);
	import tcr_pkg::*;
	logic clk_run;
	initial
	begin
		trst_n  = 1'b0;
		pins    = '0;
		clk_run = 1'b1;
	end
	always
	begin
		#15;
		if (clk_run)
		begin
			pins.bclk = ~pins.bclk;
			pins.pclk = ~pins.pclk;
		end
	end
	// Select changes before the rise so both are seen together by the sampler.
	// A quarter-nanosecond offset keeps every pin change off the sampling clock edges.
	task step(input logic m, input logic d);
		#0.25;
		pins.tms = m;
		pins.tdi = d;
		#2 pins.tck = 1'b1;
		#24 pins.tck = 1'b0;
		#21.75;
	endtask : step
	task clocks(input logic on);
		clk_run = on;
	endtask : clocks
	task test_reset(input logic v);
		pins.tms = 1'b1;
		#20 trst_n = v;
		#20;
	endtask : test_reset
endmodule : tcr_tester

// File: testbench/tb_tcr_tap.sv
// Self-checking bench for the test access port controller.
// Assumes the tester model drives every test pin and both system clocks.
`timescale 1ns/1ps
module tb_tcr_tap;
	import tcr_pkg::*;
	typedef struct packed {
		logic [2:0] instr;
		logic       run;
		logic       free;
		logic [3:0] oe;
	} tcr_row_type;
	logic          sys_clk;
	logic          rst;
	logic          trst_n;
	logic          tdo;
	logic          tdo_oe;
	logic          core_reset;
	logic          clocks_free;
	logic          in_tlr;
	logic [5:0]    dout;
	tcr_pins_type  pins;
	tcr_drive_type core_drive;
	tcr_drive_type pin_drive;
	tcr_row_type   rows [7];
	int            bad_count;
	int            n_checks;
	always #2.5 sys_clk = ~sys_clk;
	tcr_tester partner (.trst_n(trst_n), .pins(pins));
	tcr_tap uut (.sys_clk(sys_clk), .rst(rst), .trst_n(trst_n), .pins_async(pins), .core_drive(core_drive),
		.tdo(tdo), .tdo_oe(tdo_oe), .pin_drive(pin_drive), .core_reset(core_reset),
		.clocks_free(clocks_free), .in_test_logic_reset(in_tlr));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cycles
	// Output bits are taken just before each shifting rise, once the falling edge has been seen.
	task shift(input logic ir, input int n, input logic [5:0] din);
		dout = 6'h00;
		partner.step(1'b1, 1'b0);
		if (ir)
			partner.step(1'b1, 1'b0);
		partner.step(1'b0, 1'b0);
		partner.step(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			dout[i] = tdo;
			partner.step(i == n - 1, din[i]);
		end
		partner.step(1'b1, 1'b0);
		partner.step(1'b0, 1'b0);
	endtask : shift
	task await(input logic f);
		int k;
		for (k = 0; k < 300 && clocks_free !== f; k++)
			cycles(1);
		if (k == 300)
		begin
			bad_count++;
			$display("BAD %0t clock release never settled", $time);
			close_out();
		end
	endtask : await
	initial
	begin
		#300000;
		bad_count++;
		$display("BAD %0t run hung", $time);
		close_out();
	end
	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		core_drive = {4'h5, 4'hF};
		bad_count = 0;
		n_checks = 0;
		rows = '{{INSTR_SAMPLE, 1'b1, 1'b0, 4'hF}, {INSTR_EXTEST, 1'b1, 1'b1, 4'h8},
			{INSTR_HIGHZ, 1'b0, 1'b1, 4'h0}, {INSTR_DRIVE_CTL, 1'b0, 1'b1, 4'h8},
			{INSTR_POWER_DOWN, 1'b0, 1'b1, 4'h0}, {INSTR_BYPASS, 1'b1, 1'b0, 4'hF},
			{INSTR_EXTEST, 1'b1, 1'b1, 4'h8}};
		repeat (5) @(posedge sys_clk);
		#1 rst = 1'b0;
		partner.test_reset(1'b1);
		cycles(4);
		check(8'(in_tlr), 8'h01);
		check(8'({core_reset, clocks_free}), 8'h00);
		check(pin_drive, core_drive);
		repeat (5) partner.step(1'b1, 1'b0);
		cycles(2);
		check(8'(in_tlr), 8'h01);
		partner.step(1'b0, 1'b0);
		partner.step(1'b0, 1'b0);
		cycles(2);
		check(8'(in_tlr), 8'h00);
		$display("reset and idle test done");
		foreach (rows[r])
		begin
			partner.clocks(rows[r].run);
			shift(1'b1, IR_WIDTH, 6'(rows[r].instr));
			check(8'(dout), 8'(IR_CAPTURE_VALUE));
			await(rows[r].free);
			cycles(3);
			check(8'(pin_drive.oe), 8'(rows[r].oe));
			$display("instruction row %0d done", r);
		end
		shift(1'b0, BSR_WIDTH, 6'h30);
		check(8'(dout), 8'h35);
		cycles(3);
		check(pin_drive, 8'h0F);
		shift(1'b0, BSR_WIDTH, 6'h2A);
		cycles(3);
		check(pin_drive, 8'hAB);
		partner.clocks(1'b0);
		cycles(300);
		check(pin_drive, 8'hAB);
		check(8'(clocks_free), 8'h01);
		$display("boundary scan test done");
		partner.clocks(1'b1);
		partner.test_reset(1'b0);
		check(8'(in_tlr), 8'h01);
		cycles(3);
		check(pin_drive, core_drive);
		core_drive = {4'hA, 4'h6};
		cycles(2);
		check(pin_drive, 8'hA6);
		check(8'({core_reset, clocks_free}), 8'h00);
		partner.test_reset(1'b1);
		cycles(4);
		partner.step(1'b0, 1'b0);
		cycles(2);
		check(8'(in_tlr), 8'h00);
		$display("test reset test done");
		close_out();
	end
endmodule : tb_tcr_tap
bind tcr_tap tcr_tap_props u_props (.sys_clk(sys_clk), .rst(rst), .trst_n(trst_n), .pins_async(pins_async),
	.core_drive(core_drive), .tdo(tdo), .tdo_oe(tdo_oe), .pin_drive(pin_drive), .core_reset(core_reset),
	.clocks_free(clocks_free), .in_test_logic_reset(in_test_logic_reset));
